// ---- dcfr_pkg.sv ----
// package: constants, layouts and carriers for the debug compare and fifo register block
package dcfr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CMP_C_HIGH  = 6'h04;
  localparam logic [5:0] IDX_CMP_C_LOW   = 6'h05;
  localparam logic [5:0] IDX_FIFO_HIGH   = 6'h06;
  localparam logic [5:0] IDX_FIFO_LOW    = 6'h07;
  localparam logic [5:0] IDX_CMP_A_CTRL  = 6'h08;
  localparam logic [5:0] IDX_CMP_B_CTRL  = 6'h09;
  localparam logic [5:0] IDX_FIFO_EXT    = 6'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         POS_DIR_EN      = 7;
  localparam int         POS_DIR_SEL     = 6;
  localparam logic [7:0] RST_CMP_C_HIGH  = 8'h00;
  localparam logic [7:0] RST_CMP_C_LOW   = 8'h00;
  localparam logic [1:0] RST_DIR_CTRL    = 2'h0;
  localparam logic [7:0] RD_ZERO_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int         FIFO_WIDTH      = 24;
  localparam int         FIFO_DEPTH      = 4;
  localparam int         FIFO_AW         = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;     // core address bus
    logic        rw;       // 1 read cycle, 0 write cycle
    logic        valid;    // address phase valid this cycle
  } dcfr_cpu_bus_s;

  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } dcfr_fifo_word_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } dcfr_bus_state_e;

  // direction qualification: disabled passes, enabled must agree with rw
  function automatic logic dcfr_dir_ok(input logic en, input logic sel, input logic rw);
    dcfr_dir_ok = ~en | (sel == rw);
  endfunction

endpackage

// ---- dcfr_debug_regs.sv ----
// debug comparator c, capture fifo read-out and direction qualifiers on classic wishbone
//
// Contract
// - comparator c checks address bits 15..8 against its high match byte.
// - comparator c checks address bits 7..0 against its low match byte.
// - stored 0 needs address bit low, stored 1 needs it high.
// - end-run reset with debug enabled and begin clear keeps register contents.
// - fifo high read returns bits 15..8 of word at read pointer.
// - in event-only modes fifo high reads zero for valid words.
// - fifo low read returns low byte and advances the read pointer.
// - comparator a enable 0 ignores direction, 1 includes it.
// - comparator a select 0 matches writes, 1 reads; ignored when disabled.
// - comparator b enable 0 ignores direction, 1 includes it.
// - comparator b select 0 matches writes, 1 reads; ignored when disabled.
// - full modes qualify b with comparator a bits, ignoring b's own.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// capture fifo
// ------------------------------------------------------------------
module dcfr_fifo #(
  parameter int W  = dcfr_pkg::FIFO_WIDTH,
  parameter int D  = dcfr_pkg::FIFO_DEPTH,
  parameter int AW = dcfr_pkg::FIFO_AW
) (
  input  wire logic          clk_i,
  input  wire logic          clear_i,
  input  wire logic          in_valid_i,
  input  wire logic [W-1:0]  in_data_i,
  output logic               in_ready_o,
  output logic               out_valid_o,
  output logic [W-1:0]       out_data_o,
  input  wire logic          out_ready_i,
  output logic [AW:0]        count_o
);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          push;
  logic          pop;

  // honest full and empty from the level
  assign in_ready_o  = (count_reg != D[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign count_o     = count_reg;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and level next values
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // pointers clear only on a clearing reset
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage, no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule

// ------------------------------------------------------------------
// register block top
// ------------------------------------------------------------------
module dcfr_debug_regs (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     end_run_reset_i,
  input  wire logic                     debug_unit_enable_i,
  input  wire logic                     begin_trigger_i,
  input  wire logic                     event_only_mode_i,
  input  wire logic                     full_mode_i,
  input  wire dcfr_pkg::dcfr_cpu_bus_s  cpu_bus_i,
  input  wire logic                     cof_valid_i,
  input  wire dcfr_pkg::dcfr_fifo_word_s cof_data_i,
  output logic                          cof_ready_o,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          cmp_c_match_o,
  output logic                          cmp_a_dir_ok_o,
  output logic                          cmp_b_dir_ok_o
);
  import dcfr_pkg::*;

  dcfr_bus_state_e bus_state_reg;
  dcfr_bus_state_e bus_state_next;
  logic [31:0]     dat_reg;
  logic [31:0]     dat_next;
  logic [7:0]      cch_reg;
  logic [7:0]      cch_next;
  logic [7:0]      ccl_reg;
  logic [7:0]      ccl_next;
  logic [1:0]      a_ctrl_reg;
  logic [1:0]      a_ctrl_next;
  logic [1:0]      b_ctrl_reg;
  logic [1:0]      b_ctrl_next;
  logic            c_hit_reg;
  logic            c_hit_next;
  logic            a_ok_reg;
  logic            a_ok_next;
  logic            b_ok_reg;
  logic            b_ok_next;
  logic            keep_hold;
  logic            clear;
  logic            req;
  logic            aligned;
  logic [5:0]      idx;
  logic            wr_lane0;
  logic            fifo_pop;
  logic            fifo_valid;
  dcfr_fifo_word_s fifo_word;
  logic [2:0]      fifo_count;

  // ----------------------------------------------------------------
  // reset qualification
  // ----------------------------------------------------------------
  // end-run hold
  assign keep_hold = end_run_reset_i & debug_unit_enable_i & ~begin_trigger_i;
  assign clear     = rst_i & ~keep_hold;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  assign req      = wb_cyc_i & wb_stb_i & (bus_state_reg == BUS_IDLE);
  assign aligned  = (wb_adr_i[1:0] == 2'h0);
  assign idx      = wb_adr_i[7:2];
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0] & aligned;
  assign wb_ack_o = (bus_state_reg == BUS_ACK);
  assign wb_dat_o = dat_reg;

  // single pop per access
  // no pop while a reset is in force, so an end-run reset keeps the pointers
  assign fifo_pop = req & ~rst_i & ~wb_we_i & aligned & (idx == IDX_FIFO_LOW);

  // bus state and read data next values
  always_comb begin
    bus_state_next = BUS_IDLE;
    dat_next       = dat_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (req) begin
          bus_state_next = BUS_ACK;
          dat_next       = 32'h0;
          if (!wb_we_i && aligned) begin
            case (idx)
              IDX_CMP_C_HIGH: dat_next[7:0] = cch_reg;
              IDX_CMP_C_LOW:  dat_next[7:0] = ccl_reg;
              IDX_FIFO_HIGH:  dat_next[7:0] = (fifo_valid && !event_only_mode_i) ?
                                              fifo_word.high : RD_ZERO_BYTE;
              IDX_FIFO_LOW:   dat_next[7:0] = fifo_valid ? fifo_word.low : RD_ZERO_BYTE;
              IDX_FIFO_EXT:   dat_next[7:0] = (fifo_valid && !event_only_mode_i) ?
                                              fifo_word.ext : RD_ZERO_BYTE;
              IDX_CMP_A_CTRL: dat_next[7:6] = a_ctrl_reg;
              IDX_CMP_B_CTRL: dat_next[7:6] = b_ctrl_reg;
              default:        dat_next      = 32'h0;
            endcase
          end
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // bus slave state, ordinary reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= BUS_IDLE;
      dat_reg       <= 32'h0;
    end else begin
      bus_state_reg <= bus_state_next;
      dat_reg       <= dat_next;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_comb begin
    cch_next    = cch_reg;
    ccl_next    = ccl_reg;
    a_ctrl_next = a_ctrl_reg;
    b_ctrl_next = b_ctrl_reg;
    if (wr_lane0) begin
      case (idx)
        IDX_CMP_C_HIGH: cch_next    = wb_dat_i[7:0];
        IDX_CMP_C_LOW:  ccl_next    = wb_dat_i[7:0];
        IDX_CMP_A_CTRL: a_ctrl_next = wb_dat_i[POS_DIR_EN:POS_DIR_SEL];
        IDX_CMP_B_CTRL: b_ctrl_next = wb_dat_i[POS_DIR_EN:POS_DIR_SEL];
        default:        cch_next    = cch_reg;
      endcase
    end
  end

  // registers keep contents unless a clearing reset
  always_ff @(posedge clk_i) begin
    if (clear) begin
      cch_reg    <= RST_CMP_C_HIGH;
      ccl_reg    <= RST_CMP_C_LOW;
      a_ctrl_reg <= RST_DIR_CTRL;
      b_ctrl_reg <= RST_DIR_CTRL;
    end else if (!rst_i) begin
      cch_reg    <= cch_next;
      ccl_reg    <= ccl_next;
      a_ctrl_reg <= a_ctrl_next;
      b_ctrl_reg <= b_ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // comparators and direction qualifiers
  // ----------------------------------------------------------------
  always_comb begin
    c_hit_next = cpu_bus_i.valid &
                 (cpu_bus_i.addr[15:8] == cch_reg) &
                 (cpu_bus_i.addr[7:0] == ccl_reg);
    a_ok_next  = cpu_bus_i.valid &
                 dcfr_dir_ok(a_ctrl_reg[1], a_ctrl_reg[0], cpu_bus_i.rw);
    // full modes use comparator a bits
    if (full_mode_i) begin
      b_ok_next = a_ok_next;
    end else begin
      b_ok_next = cpu_bus_i.valid &
                  dcfr_dir_ok(b_ctrl_reg[1], b_ctrl_reg[0], cpu_bus_i.rw);
    end
  end

  // registered match strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_hit_reg <= 1'b0;
      a_ok_reg  <= 1'b0;
      b_ok_reg  <= 1'b0;
    end else begin
      c_hit_reg <= c_hit_next;
      a_ok_reg  <= a_ok_next;
      b_ok_reg  <= b_ok_next;
    end
  end

  assign cmp_c_match_o  = c_hit_reg;
  assign cmp_a_dir_ok_o = a_ok_reg;
  assign cmp_b_dir_ok_o = b_ok_reg;

  // ----------------------------------------------------------------
  // capture fifo instance
  // ----------------------------------------------------------------
  dcfr_fifo #(
    .W  (FIFO_WIDTH),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .clear_i     (clear),
    .in_valid_i  (cof_valid_i & ~rst_i),
    .in_data_i   (cof_data_i),
    .in_ready_o  (cof_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_word),
    .out_ready_i (fifo_pop),
    .count_o     (fifo_count)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic push_fire;
  assign push_fire = cof_valid_i & cof_ready_o;

  a_cmp_c_high: assert property (
    cpu_bus_i.valid && (cpu_bus_i.addr[15:8] != cch_reg) |=> !cmp_c_match_o)
    else $error("comparator c matched with differing high byte");

  a_cmp_c_low: assert property (
    cpu_bus_i.valid && (cpu_bus_i.addr[7:0] != ccl_reg) |=> !cmp_c_match_o)
    else $error("comparator c matched with differing low byte");

  a_cmp_c_hit: assert property (
    cpu_bus_i.valid && (cpu_bus_i.addr == {cch_reg, ccl_reg}) |=> cmp_c_match_o)
    else $error("comparator c missed an exact address");

  a_hold_end_run: assert property (disable iff (1'b0)
    rst_i && keep_hold |=> $stable({cch_reg, ccl_reg, a_ctrl_reg, b_ctrl_reg, fifo_count}))
    else $error("end-run reset disturbed held registers");

  a_fifo_high_read: assert property (
    fifo_valid && !event_only_mode_i && req && !wb_we_i && aligned && idx == IDX_FIFO_HIGH
    |=> wb_ack_o && wb_dat_o[7:0] == $past(fifo_word.high) && wb_dat_o[31:8] == 24'h0)
    else $error("fifo high read returned wrong byte");

  a_fifo_high_zero: assert property (
    event_only_mode_i && req && !wb_we_i && aligned && idx == IDX_FIFO_HIGH
    |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("fifo high not zero in event-only mode");

  a_fifo_low_pop: assert property (
    fifo_valid && req && !wb_we_i && aligned && idx == IDX_FIFO_LOW
    |=> wb_dat_o[7:0] == $past(fifo_word.low) &&
        fifo_count == $past(fifo_count) - 3'h1 + {2'h0, $past(push_fire)})
    else $error("fifo low read did not pop exactly once");

  a_ptr_hold_upper: assert property (
    req && !wb_we_i && (idx == IDX_FIFO_HIGH || idx == IDX_FIFO_EXT)
    |=> fifo_count == $past(fifo_count) + {2'h0, $past(push_fire)} ##1
        fifo_count >= $past(fifo_count))
    else $error("upper byte read moved the fifo pointer");

  a_dir_a_off: assert property (
    cpu_bus_i.valid && !a_ctrl_reg[1] |=> cmp_a_dir_ok_o)
    else $error("comparator a qualified direction while disabled");

  a_dir_a_sel: assert property (
    cpu_bus_i.valid && a_ctrl_reg[1] && (cpu_bus_i.rw != a_ctrl_reg[0]) |=> !cmp_a_dir_ok_o)
    else $error("comparator a accepted wrong direction");

  a_dir_b_off: assert property (
    cpu_bus_i.valid && !full_mode_i && !b_ctrl_reg[1] |=> cmp_b_dir_ok_o)
    else $error("comparator b qualified direction while disabled");

  a_dir_b_sel: assert property (
    cpu_bus_i.valid && !full_mode_i && b_ctrl_reg[1] && (cpu_bus_i.rw != b_ctrl_reg[0])
    |=> !cmp_b_dir_ok_o)
    else $error("comparator b accepted wrong direction");

  a_full_uses_a: assert property (
    full_mode_i |=> cmp_b_dir_ok_o == cmp_a_dir_ok_o)
    else $error("full mode b qualifier differs from a");

  c_low_pop: cover property (fifo_pop && fifo_valid ##1 wb_ack_o);
  c_event_high: cover property (event_only_mode_i && fifo_valid && req && idx == IDX_FIFO_HIGH);
  c_c_match: cover property (cmp_c_match_o);
  c_fifo_full: cover property (!cof_ready_o && cof_valid_i);
endmodule

// ---- dcfr_core_model.sv ----
// processor core address bus model feeding the comparators
`timescale 1ns/1ps

// ----
// core bus model
// ----
module dcfr_core_model (
  input  wire logic               clk_i,
  output dcfr_pkg::dcfr_cpu_bus_s bus_o
);
  import dcfr_pkg::*;

  // idle bus at time zero
  initial begin
    bus_o = '0;
  end

  // drives the bus valid and leaves it valid; returns once the registered outputs have updated
  task automatic drive(input logic [15:0] addr, input logic rw);
    @(posedge clk_i);
    bus_o <= '{addr: addr, rw: rw, valid: 1'b0 | 1'b1};
    @(posedge clk_i);
    #1;
  endtask

  // released bus shows inverted lines so stale values never match by chance
  task automatic release_bus();
    @(posedge clk_i);
    bus_o <= '{addr: ~bus_o.addr, rw: ~bus_o.rw, valid: 1'b0};
  endtask
endmodule

// ---- dcfr_debug_regs_tb.sv ----
// self-checking bench for the debug compare and fifo register block
`timescale 1ns/1ps

module dcfr_debug_regs_tb;
  import dcfr_pkg::*;

  // ----
  // signals and instances
  // ----
  localparam logic [7:0] A_CH = {IDX_CMP_C_HIGH, 2'b00}, A_CL = {IDX_CMP_C_LOW, 2'b00};
  localparam logic [7:0] A_FH = {IDX_FIFO_HIGH, 2'b00},  A_FL = {IDX_FIFO_LOW, 2'b00};
  localparam logic [7:0] A_AX = {IDX_CMP_A_CTRL, 2'b00}, A_BX = {IDX_CMP_B_CTRL, 2'b00};
  localparam logic [7:0] A_FX = {IDX_FIFO_EXT, 2'b00};
  logic            clk_i, rst_i, end_run_reset_i, debug_unit_enable_i, begin_trigger_i;
  logic            event_only_mode_i, full_mode_i, cof_valid_i, cof_ready_o;
  logic            wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic            cmp_c_match_o, cmp_a_dir_ok_o, cmp_b_dir_ok_o;
  logic [7:0]      wb_adr_i;
  logic [3:0]      wb_sel_i;
  logic [31:0]     wb_dat_i, wb_dat_o;
  dcfr_cpu_bus_s   cpu_bus;
  dcfr_fifo_word_s cof_data_i;
  int              mismatches, cmp_count;

  dcfr_core_model core_u (.clk_i(clk_i), .bus_o(cpu_bus));

  dcfr_debug_regs dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .end_run_reset_i(end_run_reset_i),
    .debug_unit_enable_i(debug_unit_enable_i), .begin_trigger_i(begin_trigger_i),
    .event_only_mode_i(event_only_mode_i), .full_mode_i(full_mode_i),
    .cpu_bus_i(cpu_bus), .cof_valid_i(cof_valid_i), .cof_data_i(cof_data_i),
    .cof_ready_o(cof_ready_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_c_match_o(cmp_c_match_o),
    .cmp_a_dir_ok_o(cmp_a_dir_ok_o), .cmp_b_dir_ok_o(cmp_b_dir_ok_o)
  );

  // 40 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----
  // shared tasks
  // ----
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %0t: %s got %h want %h", $time, what, got, exp);
      mismatches++;
    end
  endtask

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                    output logic [31:0] rdat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      $display("unexpected %0t: no bus acknowledge", $time);
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] unused;
    wb(1'b1, adr, d, unused);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp, input string what);
    logic [31:0] got;
    wb(1'b0, adr, 8'h00, got);
    chk(got, {24'h0, exp}, what);
  endtask

  // offer one capture word until the fifo takes it
  task automatic push(input logic [23:0] w);
    int n;
    @(posedge clk_i);
    cof_valid_i <= 1'b1;
    cof_data_i  <= w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cof_ready_o !== 1'b1 && n < 20);
    cof_valid_i <= 1'b0;
    if (n >= 20) begin
      $display("unexpected %0t: capture word never taken", $time);
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic do_reset(input logic keep);
    @(posedge clk_i);
    rst_i           <= 1'b1;
    end_run_reset_i <= keep;
    repeat (3) @(posedge clk_i);
    rst_i           <= 1'b0;
    end_run_reset_i <= 1'b0;
  endtask

  // upper bytes read before the popping low byte
  task automatic rd_word(input logic [23:0] exp, input logic ev);
    rdc(A_FX, ev ? 8'h00 : exp[23:16], "fifo ext");
    rdc(A_FH, ev ? 8'h00 : exp[15:8], "fifo high");
    rdc(A_FL, exp[7:0], "fifo low");
  endtask

  // ----
  // scenarios
  // ----
  task automatic s_reset_values();
    rdc(A_CH, 8'h00, "c high reset");
    rdc(A_CL, 8'h00, "c low reset");
    rdc(A_FH, 8'h00, "fifo high reset");
    rdc(A_FL, 8'h00, "empty low");
    rdc(A_AX, 8'h00, "a ctrl reset");
    rdc(A_BX, 8'h00, "b ctrl reset");
    rdc(8'h2c, 8'h00, "unmapped");
  endtask

  task automatic s_cmp_c();
    logic [15:0] adrs [5] = '{16'ha53c, 16'ha53d, 16'h253c, 16'ha43c, 16'ha5bc};
    wr(A_CH, 8'ha5);
    wr(A_CL, 8'h3c);
    rdc(A_CH, 8'ha5, "c high back");
    rdc(A_CL, 8'h3c, "c low back");
    for (int i = 0; i < 5; i++) begin
      core_u.drive(adrs[i], i[0]);
      chk(cmp_c_match_o, i == 0, "c match");
    end
    core_u.release_bus();
  endtask

  task automatic s_dir();
    for (int i = 0; i < 16; i++) begin
      logic fm, en, sel, rw, ea, eb;
      {fm, en, sel, rw} = i[3:0];
      wr(A_AX, {en, sel, 6'h00});
      wr(A_BX, {~en, ~sel, 6'h00});
      full_mode_i <= fm;
      core_u.drive(16'h1234, rw);
      ea = ~en | (sel == rw);
      eb = fm ? ea : (en | (~sel == rw));
      chk(cmp_a_dir_ok_o, ea, "dir a");
      chk(cmp_b_dir_ok_o, eb, "dir b");
    end
    core_u.release_bus();
    wr(A_AX, 8'hff);
    rdc(A_AX, 8'hc0, "a ctrl bits");
    wr(A_BX, 8'hff);
    rdc(A_BX, 8'hc0, "b ctrl bits");
    full_mode_i <= 1'b0;
  endtask

  task automatic s_fifo();
    logic [23:0] w [4] = '{24'h11a1b1, 24'h22a2b2, 24'h33a3b3, 24'h44a4b4};
    for (int i = 0; i < 4; i++) begin
      push(w[i]);
    end
    #1;
    chk(cof_ready_o, 1'b0, "fifo full");
    wr(A_FH, 8'hff);
    rdc(A_FH, w[0][15:8], "high no pop");
    rd_word(w[0], 1'b0);
    event_only_mode_i <= 1'b1;
    rd_word(w[1], 1'b1);
    event_only_mode_i <= 1'b0;
    rd_word(w[2], 1'b0);
    rd_word(w[3], 1'b0);
    rdc(A_FL, 8'h00, "drained");
    chk(cof_ready_o, 1'b1, "fifo ready");
  endtask

  task automatic s_keep();
    wr(A_CH, 8'h5a);
    wr(A_BX, 8'h80);
    push(24'h0c0d0e);
    debug_unit_enable_i <= 1'b1;
    begin_trigger_i     <= 1'b0;
    do_reset(1'b1);
    rdc(A_CH, 8'h5a, "kept c high");
    rdc(A_BX, 8'h80, "kept b ctrl");
    rdc(A_FH, 8'h0d, "kept fifo");
    rdc(A_FL, 8'h0e, "kept low");
    push(24'h0f0f0f);
    begin_trigger_i <= 1'b1;
    do_reset(1'b1);
    rdc(A_CH, 8'h00, "cleared c high");
    rdc(A_FL, 8'h00, "cleared fifo");
    debug_unit_enable_i <= 1'b0;
    begin_trigger_i     <= 1'b0;
  endtask

  // main sequence
  initial begin
    mismatches          = 0;
    cmp_count           = 0;
    rst_i               = 1'b1;
    end_run_reset_i     = 1'b0;
    debug_unit_enable_i = 1'b0;
    begin_trigger_i     = 1'b0;
    event_only_mode_i   = 1'b0;
    full_mode_i         = 1'b0;
    cof_valid_i         = 1'b0;
    cof_data_i          = '0;
    wb_cyc_i            = 1'b0;
    wb_stb_i            = 1'b0;
    wb_we_i             = 1'b0;
    wb_adr_i            = 8'h00;
    wb_sel_i            = 4'h0;
    wb_dat_i            = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset_values();
    s_cmp_c();
    s_dir();
    s_fifo();
    s_keep();
    wrap_up();
  end
endmodule
